// file: hw/dol_pkg.sv
// shared constants and types for the device out-of-band link bring-up block
package dol_pkg;
  localparam int CLK_PS = 10000;
  localparam int BURST_PS = 106700;
  localparam int WAKE_GAP_PS = 106700;
  localparam int INIT_GAP_PS = 320000;
  localparam int IDLE_MAX_PS = 175000 + 53300;
  localparam int HOST_D102_NS = 533;
  localparam int OOB_BURSTS = 6;
  localparam int DWORD_NUM_NS = 80;
  localparam int DWORD_DEN = 3;
  localparam int CLK_NS = CLK_PS / 1000;

  function automatic int dol_cyc_up(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : dol_cyc_up

  localparam int BURST_CYC = dol_cyc_up(BURST_PS);
  localparam int WAKE_GAP_CYC = dol_cyc_up(WAKE_GAP_PS);
  localparam int INIT_GAP_CYC = dol_cyc_up(INIT_GAP_PS);
  localparam int IDLE_MAX_CYC = IDLE_MAX_PS / CLK_PS;
  localparam int DWORD_STEP = CLK_NS * DWORD_DEN;
  localparam int GUARD_DWORDS = (HOST_D102_NS * DWORD_DEN + DWORD_NUM_NS - 1) / DWORD_NUM_NS;

  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int CTRL_CAL_BIT = 0;
  localparam int CTRL_INIT_BIT = 1;
  localparam logic CAL_EN_RESET = 1'h1;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_COMINIT = 4'h1,
    ST_AWAIT_WAKE = 4'h3,
    ST_AWAIT_NOWAKE = 4'h2,
    ST_CALIB = 4'h6,
    ST_COMWAKE = 4'h7,
    ST_SEND_ALIGN = 4'h5,
    ST_READY = 4'h4,
    ST_REDUCE = 4'hC,
    ST_ERROR = 4'hD,
    ST_PARTIAL = 4'hF,
    ST_SLUMBER = 4'hE
  } dol_state_type;

  typedef enum logic [1:0] {
    TX_QUIET = 2'h0,
    TX_D102 = 2'h1,
    TX_ALIGN = 2'h2,
    TX_DATA = 2'h3
  } dol_tx_type;

  typedef enum logic {
    OOB_INIT = 1'h0,
    OOB_WAKE = 1'h1
  } dol_oob_type;
endpackage : dol_pkg

// file: hw/dol_burst_if.sv
// carrier between the bring-up state machine and its burst sequencer
`timescale 1ns/1ns
interface dol_burst_if;
  logic start;
  logic abort;
  dol_pkg::dol_oob_type kind;
  logic done;
  logic burst;
  modport ctl (output start, output abort, output kind, input done, input burst);
  modport gen (input start, input abort, input kind, output done, output burst);
endinterface : dol_burst_if

// file: hw/dol_burst_gen.sv
// out-of-band burst sequencer for the init and wake patterns
`timescale 1ns/1ns
module dol_burst_gen #(
  parameter int COMINIT_MULT = 1
)(
  input wire logic core_clk,
  input wire logic reset,
  dol_burst_if.gen bus
);
  localparam logic [7:0] INIT_TOTAL = 8'(dol_pkg::OOB_BURSTS * COMINIT_MULT);
  localparam logic [7:0] WAKE_TOTAL = 8'(dol_pkg::OOB_BURSTS);
  localparam logic [8:0] ON_LAST = 9'(dol_pkg::BURST_CYC - 1);

  logic active;
  logic isWake;
  logic [7:0] bursts;
  logic [8:0] phaseCnt;
  logic [8:0] gapCnt;
  wire logic [7:0] total = isWake ? WAKE_TOTAL : INIT_TOTAL;
  wire logic [8:0] gapLast = isWake ? 9'(dol_pkg::WAKE_GAP_CYC - 1)
                                    : 9'(dol_pkg::INIT_GAP_CYC - 1);
  wire logic phaseEnd = bus.burst ? (phaseCnt == ON_LAST) : (phaseCnt == gapLast);
  wire logic lastGap = !bus.burst && phaseEnd && (bursts == total);

  always_ff @(posedge core_clk) begin
    if (reset || bus.abort) begin
      active <= 1'b0;
      bus.burst <= 1'b0;
      bus.done <= 1'b0;
      bursts <= 8'h00;
      phaseCnt <= 9'h000;
      isWake <= 1'b0;
    end else if (bus.start) begin
      active <= 1'b1;
      isWake <= (bus.kind == dol_pkg::OOB_WAKE);
      bus.burst <= 1'b1;
      bus.done <= 1'b0;
      bursts <= 8'h01;
      phaseCnt <= 9'h000;
    end else begin
      bus.done <= active && lastGap;
      if (active) begin
        phaseCnt <= phaseEnd ? 9'h000 : phaseCnt + 9'h001;
        if (lastGap) begin
          active <= 1'b0;
        end else if (phaseEnd) begin
          bus.burst <= !bus.burst;
          if (!bus.burst) begin
            bursts <= bursts + 8'h01;
          end
        end
      end
    end
  end

  // idle spacing watcher, only read by assertions
  always_ff @(posedge core_clk) begin
    if (reset || bus.burst || !active) begin
      gapCnt <= 9'h000;
    end else begin
      gapCnt <= gapCnt + 9'h001;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_burst_count: assert property (bus.done |-> bursts == $past(total))
    else $error("burst sequence ended with wrong burst count");
  a_burst_width: assert property ($rose(bus.burst) |-> bus.burst [*8])
    else $error("burst shorter than minimum");
  a_idle_bound: assert property (gapCnt <= 9'(dol_pkg::INIT_GAP_CYC))
    else $error("idle gap too long");
endmodule : dol_burst_gen

// file: hw/dol_oob_init_fsm.sv
// device-side out-of-band bring-up, speed negotiation and power state machine
`timescale 1ns/1ns
module dol_oob_init_fsm #(
  parameter int NUM_SPEEDS = 2,
  parameter int ALIGN_DWORDS = 2048,
  parameter int EXTRA_DWORDS = 0,
  parameter int COMINIT_MULT = 1
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comResetDetected,
  input wire logic comWakeDetected,
  input wire logic alignDetected,
  input wire logic rxLocked,
  input wire logic pllLocked,
  input wire logic calDone,
  input wire logic speedChangeDone,
  input wire logic partialRequest,
  input wire logic slumberRequest,
  output logic oobBurst,
  output dol_pkg::dol_tx_type txSel,
  output logic [1:0] txSpeed,
  output logic calibrate,
  output logic linkUpIndication,
  output logic partialMode,
  output logic slumberMode
);
  localparam logic [12:0] ALIGN_LIMIT = 13'(ALIGN_DWORDS + EXTRA_DWORDS);
  localparam logic [12:0] GUARD = 13'(dol_pkg::GUARD_DWORDS);
  localparam logic [1:0] FASTEST = 2'(NUM_SPEEDS - 1);
  localparam logic [6:0] DWORD_WRAP = 7'(dol_pkg::DWORD_NUM_NS);
  localparam logic [6:0] DWORD_STEP = 7'(dol_pkg::DWORD_STEP);

  dol_pkg::dol_state_type state;
  dol_pkg::dol_state_type next_state;
  dol_burst_if burst ();

  logic calEnable;
  logic resuming;
  logic resumeFail;
  logic partialRec;
  logic slumberRec;
  logic [6:0] dwordAcc;
  logic [12:0] alignCnt;
  logic startPulse;
  logic oobKind;

  // register bus decode
  wire logic busReq = avs_read || avs_write;
  wire logic ctrlHit = avs_address == dol_pkg::CTRL_OFS;
  wire logic statusHit = avs_address == dol_pkg::STATUS_OFS;
  wire logic writeTaken = avs_write && !avs_waitrequest;
  wire logic ctrlWrite = writeTaken && ctrlHit;
  wire logic initReq = ctrlWrite && avs_writedata[dol_pkg::CTRL_INIT_BIT];
  wire logic [31:0] ctrlWord = {30'h0, 1'b0, calEnable};
  wire logic [31:0] statusWord = {
    20'h0, resumeFail, slumberRec, partialRec, resuming,
    linkUpIndication, 1'b0, txSpeed, state
  };
  wire logic [31:0] readMux = ctrlHit ? ctrlWord : (statusHit ? statusWord : 32'h0);

  // link condition decode
  wire logic dwordTick = (dwordAcc + DWORD_STEP) >= DWORD_WRAP;
  wire logic timeout = alignCnt >= ALIGN_LIMIT;
  wire logic guardOver = alignCnt >= GUARD;
  wire logic hostAlign = alignDetected && rxLocked && guardOver;
  wire logic atLowest = txSpeed == 2'h0;
  wire logic wakeDone = burst.done;
  wire logic enterWake = next_state == dol_pkg::ST_COMWAKE && state != dol_pkg::ST_COMWAKE;
  wire logic enterInit = next_state == dol_pkg::ST_COMINIT && state != dol_pkg::ST_COMINIT;
  wire logic enterAlign = next_state == dol_pkg::ST_SEND_ALIGN
                          && state == dol_pkg::ST_COMWAKE;
  wire logic enterReduce = next_state == dol_pkg::ST_REDUCE && state != dol_pkg::ST_REDUCE;
  wire logic enterPower = next_state == dol_pkg::ST_PARTIAL || next_state == dol_pkg::ST_SLUMBER;
  wire logic inReady = next_state == dol_pkg::ST_READY;
  wire logic nextLinkUp = inReady && rxLocked && pllLocked;

  always_comb begin
    next_state = state;
    case (state)
      dol_pkg::ST_RESET: begin
        next_state = dol_pkg::ST_COMINIT;
      end
      dol_pkg::ST_COMINIT: begin
        if (burst.done) begin
          next_state = dol_pkg::ST_AWAIT_WAKE;
        end
      end
      dol_pkg::ST_AWAIT_WAKE: begin
        if (comWakeDetected) begin
          next_state = dol_pkg::ST_AWAIT_NOWAKE;
        end
      end
      dol_pkg::ST_AWAIT_NOWAKE: begin
        if (!comWakeDetected) begin
          if (resuming || !calEnable) begin
            next_state = dol_pkg::ST_COMWAKE;
          end else begin
            next_state = dol_pkg::ST_CALIB;
          end
        end
      end
      dol_pkg::ST_CALIB: begin
        if (calDone) begin
          next_state = dol_pkg::ST_COMWAKE;
        end
      end
      dol_pkg::ST_COMWAKE: begin
        if (wakeDone) begin
          next_state = dol_pkg::ST_SEND_ALIGN;
        end
      end
      dol_pkg::ST_SEND_ALIGN: begin
        if (hostAlign) begin
          next_state = dol_pkg::ST_READY;
        end else if (timeout) begin
          if (resuming || atLowest) begin
            next_state = dol_pkg::ST_ERROR;
          end else begin
            next_state = dol_pkg::ST_REDUCE;
          end
        end
      end
      dol_pkg::ST_REDUCE: begin
        if (speedChangeDone) begin
          next_state = dol_pkg::ST_SEND_ALIGN;
        end
      end
      dol_pkg::ST_ERROR: begin
        if (resumeFail) begin
          next_state = dol_pkg::ST_COMWAKE;
        end
      end
      dol_pkg::ST_READY: begin
        if (partialRequest) begin
          next_state = dol_pkg::ST_PARTIAL;
        end else if (slumberRequest) begin
          next_state = dol_pkg::ST_SLUMBER;
        end
      end
      dol_pkg::ST_PARTIAL: begin
        if (!partialRequest) begin
          next_state = comWakeDetected ? dol_pkg::ST_AWAIT_NOWAKE
                                       : dol_pkg::ST_COMWAKE;
        end
      end
      dol_pkg::ST_SLUMBER: begin
        if (!slumberRequest) begin
          next_state = comWakeDetected ? dol_pkg::ST_AWAIT_NOWAKE
                                       : dol_pkg::ST_COMWAKE;
        end
      end
      default: begin
        next_state = dol_pkg::ST_RESET;
      end
    endcase
    if (initReq && state != dol_pkg::ST_RESET) begin
      next_state = dol_pkg::ST_COMINIT;
    end
    if (comResetDetected) begin
      next_state = dol_pkg::ST_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= dol_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // gen1 dword time is 80/3 ns, so a fractional accumulator keeps it exact
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dwordAcc <= 7'h00;
    end else if (dwordTick) begin
      dwordAcc <= dwordAcc + DWORD_STEP - DWORD_WRAP;
    end else begin
      dwordAcc <= dwordAcc + DWORD_STEP;
    end
  end

  // leaving align (to reduce) clears, so each speed gets a full window
  always_ff @(posedge core_clk) begin
    if (reset || state != dol_pkg::ST_SEND_ALIGN) begin
      alignCnt <= 13'h0000;
    end else if (dwordTick && !timeout) begin
      alignCnt <= alignCnt + 13'h0001;
    end
  end

  // power state record and resume tracking
  always_ff @(posedge core_clk) begin
    if (reset || next_state == dol_pkg::ST_RESET || enterInit) begin
      resuming <= 1'b0;
      partialRec <= 1'b0;
      slumberRec <= 1'b0;
    end else if (enterPower) begin
      resuming <= 1'b1;
      partialRec <= next_state == dol_pkg::ST_PARTIAL;
      slumberRec <= next_state == dol_pkg::ST_SLUMBER;
    end else if (inReady) begin
      resuming <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || next_state == dol_pkg::ST_RESET || enterInit) begin
      resumeFail <= 1'b0;
    end else if (next_state == dol_pkg::ST_ERROR && state == dol_pkg::ST_SEND_ALIGN) begin
      resumeFail <= resuming;
    end
  end

  // speed: fastest on power-on attempts, one step down per reduction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txSpeed <= FASTEST;
    end else if (enterAlign && !resuming) begin
      txSpeed <= FASTEST;
    end else if (enterReduce && !resuming) begin
      txSpeed <= txSpeed - 2'h1;
    end
  end

  // burst sequencer handshake
  always_ff @(posedge core_clk) begin
    if (reset) begin
      startPulse <= 1'b0;
      oobKind <= 1'b0;
    end else begin
      startPulse <= enterInit || enterWake;
      oobKind <= enterWake;
    end
  end

  assign burst.start = startPulse;
  assign burst.kind = oobKind ? dol_pkg::OOB_WAKE : dol_pkg::OOB_INIT;
  assign burst.abort = state == dol_pkg::ST_RESET;
  assign oobBurst = burst.burst;

  dol_burst_gen #(
    .COMINIT_MULT(COMINIT_MULT)
  ) u_burst (
    .core_clk(core_clk),
    .reset(reset),
    .bus(burst)
  );

  // line drive and link outputs registered from next state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      txSel <= dol_pkg::TX_QUIET;
      calibrate <= 1'b0;
      linkUpIndication <= 1'b0;
      partialMode <= 1'b0;
      slumberMode <= 1'b0;
    end else begin
      case (next_state)
        dol_pkg::ST_SEND_ALIGN: begin
          txSel <= pllLocked ? dol_pkg::TX_ALIGN : dol_pkg::TX_D102;
        end
        dol_pkg::ST_REDUCE: begin
          txSel <= dol_pkg::TX_D102;
        end
        dol_pkg::ST_READY: begin
          txSel <= dol_pkg::TX_DATA;
        end
        default: begin
          txSel <= dol_pkg::TX_QUIET;
        end
      endcase
      calibrate <= next_state == dol_pkg::ST_CALIB;
      linkUpIndication <= nextLinkUp;
      partialMode <= next_state == dol_pkg::ST_PARTIAL;
      slumberMode <= next_state == dol_pkg::ST_SLUMBER;
    end
  end

  // bus slave: one wait cycle, then answer; readdata loaded with the drop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      calEnable <= dol_pkg::CAL_EN_RESET;
    end else begin
      avs_waitrequest <= !(busReq && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= readMux;
      end
      if (ctrlWrite) begin
        calEnable <= avs_writedata[dol_pkg::CTRL_CAL_BIT];
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_comreset_forces: assert property (comResetDetected |=> state == dol_pkg::ST_RESET)
    else $error("host reset burst did not force reset state");
  a_reset_release: assert property (state == dol_pkg::ST_RESET && !comResetDetected
                                   |=> state == dol_pkg::ST_COMINIT)
    else $error("reset state not left after release");
  a_wake_hold: assert property (state == dol_pkg::ST_AWAIT_NOWAKE && comWakeDetected
                               && !comResetDetected && !initReq
                               |=> state == dol_pkg::ST_AWAIT_NOWAKE)
    else $error("left wake wait while host wake present");
  a_resume_skip_cal: assert property (state == dol_pkg::ST_AWAIT_NOWAKE && resuming
                                     |=> state != dol_pkg::ST_CALIB)
    else $error("resume entered calibration");
  a_wake_then_align: assert property (state == dol_pkg::ST_COMWAKE && wakeDone
                                     && !comResetDetected && !initReq
                                     |=> state == dol_pkg::ST_SEND_ALIGN)
    else $error("own wake not followed by align");
  a_align_char: assert property (state == dol_pkg::ST_SEND_ALIGN |-> txSel ==
                                ($past(pllLocked) ? dol_pkg::TX_ALIGN : dol_pkg::TX_D102))
    else $error("wrong character while sending align");
  a_timeout_step: assert property (state == dol_pkg::ST_SEND_ALIGN && timeout && !hostAlign
                                  && !resuming && !atLowest && !comResetDetected && !initReq
                                  |=> state == dol_pkg::ST_REDUCE ##1 txSpeed
                                  == $past(txSpeed, 2) - 2'h1)
    else $error("timeout did not step speed down");
  a_lowest_error: assert property (state == dol_pkg::ST_SEND_ALIGN && timeout && !hostAlign
                                  && atLowest && !comResetDetected && !initReq
                                  |=> state == dol_pkg::ST_ERROR)
    else $error("timeout at lowest speed not an error");
  a_resume_speed: assert property (resuming && state != dol_pkg::ST_RESET
                                  |=> txSpeed == $past(txSpeed))
    else $error("speed changed during resume");
  a_link_up: assert property (linkUpIndication |-> state == dol_pkg::ST_READY
                             && txSel == dol_pkg::TX_DATA)
    else $error("link-up outside ready");
  a_align_window: assert property (state == dol_pkg::ST_SEND_ALIGN |-> alignCnt <= ALIGN_LIMIT)
    else $error("align counter overran its window");
endmodule : dol_oob_init_fsm

// file: verif/dol_host_model.sv
// host phy model facing the device bring-up block
`timescale 1ns/1ns
module dol_host_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic oobBurst,
  input wire dol_pkg::dol_tx_type txSel,
  input wire logic answer,
  input wire logic hostWake,
  output logic comWakeDetected,
  output logic alignDetected,
  output logic rxLocked
);
  logic prevBurst;
  logic initGap;
  int quiet;
  int bursts;
  int wakeLeft;
  int alignRun;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prevBurst <= 1'b0;
      initGap <= 1'b0;
      quiet <= 0;
      bursts <= 0;
      wakeLeft <= 0;
      alignRun <= 0;
    end else begin
      prevBurst <= oobBurst;
      quiet <= oobBurst ? 0 : quiet + 1;
      alignRun <= (txSel == dol_pkg::TX_ALIGN) ? alignRun + 1 : 0;
      if (wakeLeft > 0) wakeLeft <= wakeLeft - 1;
      if (oobBurst && !prevBurst) begin
        bursts <= bursts + 1;
        // long gaps mark an init sequence, short ones are left unmarked
        if (quiet > 20 && quiet < 40) initGap <= 1'b1;
      end
      if (quiet == 40) begin
        bursts <= 0;
        initGap <= 1'b0;
        if (initGap && bursts >= 6) wakeLeft <= 30;
      end
    end
  end
  assign comWakeDetected = (wakeLeft > 0) || hostWake;
  // reply only after a long align run, well past the filler window
  assign alignDetected = answer && (alignRun >= 60);
  assign rxLocked = answer;
endmodule : dol_host_model

// file: verif/device_oob_link_init_fsm_bench.sv
// self-checking bench for the device bring-up state machine
`timescale 1ns/1ns
module device_oob_link_init_fsm_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic comResetDetected = 1'b0;
  logic comWakeDetected, alignDetected, rxLocked;
  logic pllLocked = 1'b1;
  logic calDone = 1'b0;
  logic speedChangeDone = 1'b0;
  logic partialRequest = 1'b0;
  logic slumberRequest = 1'b0;
  logic answer = 1'b0;
  logic hostWake = 1'b0;
  logic oobBurst, calibrate, linkUpIndication, partialMode, slumberMode;
  dol_pkg::dol_tx_type txSel;
  logic [1:0] txSpeed;
  logic [31:0] stat;
  int num_errors = 0;
  int checks_done = 0;
  int burstCount = 0;
  int calCycles = 0;
  int mark;
  logic prevBurst = 1'b0;

  always #5 core_clk = ~core_clk;

  dol_oob_init_fsm #(.NUM_SPEEDS(2), .ALIGN_DWORDS(64), .EXTRA_DWORDS(0), .COMINIT_MULT(1)) i_dut (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comResetDetected(comResetDetected),
    .comWakeDetected(comWakeDetected), .alignDetected(alignDetected), .rxLocked(rxLocked),
    .pllLocked(pllLocked), .calDone(calDone), .speedChangeDone(speedChangeDone),
    .partialRequest(partialRequest), .slumberRequest(slumberRequest), .oobBurst(oobBurst),
    .txSel(txSel), .txSpeed(txSpeed), .calibrate(calibrate),
    .linkUpIndication(linkUpIndication), .partialMode(partialMode), .slumberMode(slumberMode));

  dol_host_model i_host (
    .core_clk(core_clk), .reset(reset), .oobBurst(oobBurst), .txSel(txSel), .answer(answer),
    .hostWake(hostWake), .comWakeDetected(comWakeDetected), .alignDetected(alignDetected),
    .rxLocked(rxLocked));

  // burst and calibration tallies, sampled off the wire
  always @(posedge core_clk) begin
    prevBurst <= oobBurst;
    if (oobBurst === 1'b1 && prevBurst === 1'b0) burstCount <= burstCount + 1;
    if (calibrate === 1'b1) calCycles <= calCycles + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= addr;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    stat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus latency", 32'h2, n);
  endtask : bus

  task automatic waitState(input logic [3:0] st, input string nm);
    int i;
    i = 0;
    do begin
      bus(1'b0, 4'h4, 32'h0);
      i++;
    end while (stat[3:0] !== st && i < 600);
    chk(nm, {28'h0, st}, {28'h0, stat[3:0]});
  endtask : waitState

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", 32'h1, stat);
    bus(1'b1, 4'h4, 32'hFFFF);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, stat);
    $display("test registers done");
    waitState(4'h6, "calibrating");
    repeat (20) @(posedge core_clk);
    chk("calibrate held", 32'h1, {31'h0, calibrate});
    calDone <= 1'b1;
    waitState(4'hC, "reduce first");
    chk("first step", 32'h0, {30'h0, txSpeed});
    answer <= 1'b1;
    speedChangeDone <= 1'b1;
    waitState(4'h4, "ready");
    speedChangeDone <= 1'b0;
    chk("link up", 32'h1, {31'h0, linkUpIndication});
    chk("slow speed", 32'h0, {30'h0, txSpeed});
    chk("burst total", 32'hC, burstCount);
    $display("test power-on done");
    mark = calCycles;
    answer <= 1'b0;
    partialRequest <= 1'b1;
    waitState(4'hF, "partial");
    chk("partial mode", 32'h1, {31'h0, partialMode});
    chk("partial kept", 32'h1, {31'h0, stat[9]});
    partialRequest <= 1'b0;
    repeat (800) @(posedge core_clk);
    chk("resume speed", 32'h0, {30'h0, txSpeed});
    chk("wake again", 32'h1, {31'h0, burstCount > 18});
    answer <= 1'b1;
    waitState(4'h4, "partial resumed");
    $display("test partial done");
    slumberRequest <= 1'b1;
    waitState(4'hE, "slumber");
    chk("slumber mode", 32'h1, {31'h0, slumberMode});
    chk("slumber kept", 32'h1, {31'h0, stat[10]});
    hostWake <= 1'b1;
    slumberRequest <= 1'b0;
    waitState(4'h2, "await wake drop");
    hostWake <= 1'b0;
    waitState(4'h4, "slumber resumed");
    chk("no calibration", mark, calCycles);
    $display("test slumber done");
    answer <= 1'b0;
    pllLocked <= 1'b0;
    bus(1'b1, 4'h0, 32'h2);
    waitState(4'h5, "align state");
    chk("fast first", 32'h1, {30'h0, txSpeed});
    chk("cal bypassed", mark, calCycles);
    chk("filler", 32'h1, {30'h0, txSel});
    pllLocked <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("align sent", 32'h2, {30'h0, txSel});
    waitState(4'hC, "reduce");
    chk("slower", 32'h0, {30'h0, stat[5:4]});
    speedChangeDone <= 1'b1;
    waitState(4'hD, "error");
    repeat (300) @(posedge core_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk("error held", 32'hD, {20'h0, stat[11:0]});
    $display("test speed steps done");
    mark = burstCount;
    comResetDetected <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk("held in reset", 32'h0, {28'h0, stat[3:0]});
    comResetDetected <= 1'b0;
    waitState(4'h3, "init sent");
    chk("init bursts", 32'h6, burstCount - mark);
    $display("test host reset done");
    conclude();
  end
endmodule : device_oob_link_init_fsm_bench
